// [logic/interval_timer_map.vh]
`ifndef INTERVAL_TIMER_MAP_VH
`define INTERVAL_TIMER_MAP_VH

// control register bit positions (7-bit control register)
`define CTL_STOP_OVF   0
`define CTL_START      1
`define CTL_LOAD_OVF   2
`define CTL_LOAD_PROG  3
`define CTL_LOAD_INTR  4
`define CTL_ZERO       5
`define CTL_READ       6
`define CTL_WIDTH      7

// counter, preset and control register reset value
`define CNT_WIDTH      16
`define CNT_MAX        16'hFFFF
`define CNT_RESET      16'h0000
`define PRESET_RESET   16'h0000
`define CTL_RESET      7'h00

// timing: one counter step per microsecond tick
`define CLK_PERIOD_NS  40
`define TICK_NS        1000
`define TICK_CYCLES    ((`TICK_NS) / (`CLK_PERIOD_NS))

// data bit examined by the mask-out pulse
`define MASK_BIT_DEFAULT 0

`endif

// [logic/tick_gen.v]
`timescale 1ns/1ps

// free-running divider giving a one-cycle pulse every PERIOD cycles
module tick_gen #(
   parameter PERIOD = 25,
   parameter CW     = 8
) (
   // clock and reset
   input  wire          core_clk,
   input  wire          resetn,
   // tick out
   output reg           tick
);

   localparam [31:0]   LAST_W = PERIOD - 1;
   localparam [CW-1:0] LAST   = LAST_W[CW-1:0];

   reg [CW-1:0] div_q;

   // divider runs free so the tick phase never depends on the control bits
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= {CW{1'b0}};
         tick  <= 1'b0;
      end else if (div_q == LAST) begin
         div_q <= {CW{1'b0}};
         tick  <= 1'b1;
      end else begin
         div_q <= div_q + {{(CW-1){1'b0}}, 1'b1};
         tick  <= 1'b0;
      end
   end

endmodule

// [logic/interval_timer.v]
`timescale 1ns/1ps
`include "interval_timer_map.vh"

module interval_timer #(
   parameter CW       = `CNT_WIDTH,
   parameter TICK_CYC = `TICK_CYCLES,
   parameter MASK_BIT = `MASK_BIT_DEFAULT
) (
   // clock and reset
   input  wire          core_clk,
   input  wire          resetn,
   // programmed i/o strobes, one cycle each, for this device only
   input  wire          write_control_transfer,
   input  wire          write_control_with_pulse,
   input  wire          write_preset_transfer,
   input  wire          read_control_transfer,
   input  wire          read_count_transfer,
   input  wire          start_pulse,
   input  wire          clear_pulse,
   // bus-wide pulses
   input  wire          io_bus_reset,
   input  wire          mask_out_pulse,
   // shared 16-bit data bus
   input  wire [15:0]   data_in,
   output reg  [15:0]   data_out,
   output reg           data_oe,
   // device status toward the host
   output reg           busy,
   output reg           done,
   output reg           int_disable,
   output reg           int_req,
   // receiver side
   input  wire          interrog_pulse,
   input  wire          allcall_reset_pulse,
   // overflow pulse and live count
   output reg           early_pulse,
   output wire [15:0]   count_value
);

   // control register, preset, counter and latch
   reg  [`CTL_WIDTH-1:0] ctl_q;
   reg  [`CTL_WIDTH-1:0] ctl_d;
   reg  [CW-1:0]         preset_q;
   reg  [CW-1:0]         cnt_q;
   reg  [CW-1:0]         cnt_d;
   reg  [CW-1:0]         latch_q;
   reg                   frozen_q;
   reg                   frozen_d;
   reg                   interrog_prev_q;
   reg                   allcall_prev_q;

   wire                  tick;
   wire                  stop_ovf;
   wire                  run_en;
   wire                  load_ovf;
   wire                  load_intr;
   wire                  read_lvl;
   wire                  zero_stb;
   wire                  prog_stb;
   wire                  sample_stb;
   wire                  intr_load;
   wire                  step;
   wire                  ovf;
   wire                  interrog_rise;
   wire                  allcall_rise;

   // divider sized from its period, so a slower tick still fits
   localparam TICK_CW = (TICK_CYC > 4) ? $clog2(TICK_CYC) : 2;

   // microsecond tick from the core clock
   tick_gen #(
      .PERIOD (TICK_CYC),
      .CW     (TICK_CW)
   ) u_tick (
      .core_clk (core_clk),
      .resetn   (resetn),
      .tick     (tick)
   );

   // level bits straight from the control register
   assign stop_ovf  = ctl_q[`CTL_STOP_OVF];
   assign run_en    = ctl_q[`CTL_START];
   assign load_ovf  = ctl_q[`CTL_LOAD_OVF];
   assign load_intr = ctl_q[`CTL_LOAD_INTR];
   assign read_lvl  = ctl_q[`CTL_READ];

   // pulse bits only fire when the control write carries the P pulse;
   // a plain control write stores them but starts nothing
   assign zero_stb   = write_control_with_pulse &
                       data_in[`CTL_ZERO];
   assign prog_stb   = write_control_with_pulse &
                       data_in[`CTL_LOAD_PROG];
   assign sample_stb = write_control_with_pulse &
                       data_in[`CTL_READ];

   // receiver pulses follow the mode decoder's own timing and may last
   // several core cycles; each one acts once, at its leading edge
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         interrog_prev_q <= 1'b0;
         allcall_prev_q  <= 1'b0;
      end else begin
         interrog_prev_q <= interrog_pulse;
         allcall_prev_q  <= allcall_reset_pulse;
      end
   end

   // history resets to the idle level, so no false edge follows reset
   assign interrog_rise = interrog_pulse & ~interrog_prev_q;
   assign allcall_rise  = allcall_reset_pulse & ~allcall_prev_q;

   // interrogation load only when that source is armed; the read level
   // is not looked at, the host keeps it clear while loads are armed
   assign intr_load = load_intr & interrog_rise;

   // a step happens on each tick while started and not frozen
   assign step = tick & run_en & ~frozen_q;

   // overflow is the step out of the all-ones count
   assign ovf  = step & (cnt_q == `CNT_MAX);

   // live count, for the reply side and for diagnostics
   assign count_value = cnt_q;

   // control register: written whole by either control write; overflow
   // drops the stop gate so the next arming is a deliberate act
   always @* begin
      ctl_d = ctl_q;
      if (write_control_transfer | write_control_with_pulse) begin
         ctl_d = data_in[`CTL_WIDTH-1:0];
      end
      // the gate drop wins over a write landing in the same cycle
      if (ovf & stop_ovf) begin
         ctl_d[`CTL_STOP_OVF] = 1'b0;
      end
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctl_q <= `CTL_RESET;
      end else if (io_bus_reset) begin
         ctl_q <= `CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // preset register, written by the preset transfer only
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         preset_q <= `PRESET_RESET;
      end else if (write_preset_transfer) begin
         preset_q <= data_in[CW-1:0];
      end
   end

   // counter next value; zero strobe beats everything, explicit loads beat
   // the all-call reset so an all-call interrogation can still preset
   always @* begin
      cnt_d    = cnt_q;
      frozen_d = frozen_q;
      if (zero_stb) begin
         cnt_d    = `CNT_RESET;
         frozen_d = 1'b0;
      end else if (prog_stb) begin
         cnt_d    = preset_q;
         frozen_d = 1'b0;
      end else if (intr_load) begin
         cnt_d    = preset_q;
         frozen_d = 1'b0;
      end else if (allcall_rise) begin
         cnt_d    = `CNT_RESET;
         frozen_d = 1'b0;
      end else if (ovf) begin
         if (load_ovf) begin
            cnt_d = preset_q;
         end else if (stop_ovf) begin
            cnt_d = cnt_q;
         end else begin
            // neither gate set: wrap to zero and keep counting
            cnt_d = `CNT_RESET;
         end
         // a set stop gate holds the count until a load or a zero
         if (stop_ovf) begin
            frozen_d = 1'b1;
         end
      end else if (step) begin
         cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // a frozen counter stays put until it is loaded or zeroed
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q    <= `CNT_RESET;
         frozen_q <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         frozen_q <= frozen_d;
      end
   end

   // holding latch samples the live count; the counter is not touched
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         latch_q <= `CNT_RESET;
      end else if (sample_stb) begin
         latch_q <= cnt_q;
      end
   end

   // read answers: registered word and enable for one cycle after the
   // strobe; the count is only driven when the read level is set, since
   // the drivers share the bus with the preset path
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         data_out <= 16'h0000;
         data_oe  <= 1'b0;
      end else if (read_control_transfer) begin
         data_out <= {{(16-`CTL_WIDTH){1'b0}}, ctl_q};
         data_oe  <= 1'b1;
      end else if (read_count_transfer & read_lvl) begin
         data_out <= latch_q;
         data_oe  <= 1'b1;
      end else begin
         // nothing asked: drivers off and no stale word left behind
         data_out <= 16'h0000;
         data_oe  <= 1'b0;
      end
   end

   // early pulse to reply generators, one cycle per overflow
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         early_pulse <= 1'b0;
      end else begin
         early_pulse <= ovf;
      end
   end

   // busy/done: completion is the overflow event; it outranks a clear or
   // start in the same cycle so a finished interval is never lost
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         done <= 1'b0;
      end else if (ovf) begin
         busy <= 1'b0;
         done <= 1'b1;
      end else if (io_bus_reset | clear_pulse) begin
         busy <= 1'b0;
         done <= 1'b0;
      end else if (start_pulse) begin
         busy <= 1'b1;
         done <= 1'b0;
      end
   end

   // interrupt disable follows its own data bit on mask-out
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         int_disable <= 1'b0;
      end else if (io_bus_reset) begin
         int_disable <= 1'b0;
      end else if (mask_out_pulse) begin
         int_disable <= data_in[MASK_BIT];
      end
   end

   // request is a level: done and not disabled, so clearing the disable
   // with done pending raises it again one cycle later
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         int_req <= 1'b0;
      end else begin
         int_req <= done & ~int_disable;
      end
   end

endmodule

// [test/interval_timer_sva.sv]
`timescale 1ns/1ps
// pin-level checks on the timer, host strobes treated as causes
module interval_timer_sva #(
   parameter MASK_BIT = 0
) (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        resetn,
   // host and receiver strobes
   input wire logic        write_control_with_pulse,
   input wire logic        read_control_transfer,
   input wire logic        read_count_transfer,
   input wire logic        start_pulse,
   input wire logic        clear_pulse,
   input wire logic        io_bus_reset,
   input wire logic        mask_out_pulse,
   input wire logic        interrog_pulse,
   input wire logic        allcall_reset_pulse,
   input wire logic [15:0] data_in,
   // answers and status
   input wire logic [15:0] data_out,
   input wire logic        data_oe,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        int_disable,
   input wire logic        int_req,
   input wire logic        early_pulse,
   input wire logic [15:0] count_value
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // sample pulse then count read on the very next cycle
   sequence s_sample;
      write_control_with_pulse && data_in[6];
   endsequence
   sequence s_read_cnt;
      s_sample ##1 read_count_transfer;
   endsequence

   a_count_read: assert property (s_read_cnt |=>
      data_oe && data_out == $past(count_value, 2)) else $error("bad count");
   a_oe_cause: assert property (data_oe |->
      $past(read_control_transfer || read_count_transfer)) else $error("oe");
   a_zero_count: assert property (write_control_with_pulse && data_in[5]
      |=> count_value == 16'h0000) else $error("zero failed");
   a_allcall_zero: assert property (allcall_reset_pulse &&
      !$past(allcall_reset_pulse) && !interrog_pulse &&
      !write_control_with_pulse |=> count_value == 16'h0000) else $error("ac");
   a_done_early: assert property (early_pulse |-> done && !busy)
      else $error("early without done");
   a_start_busy: assert property (start_pulse && !clear_pulse &&
      !io_bus_reset |=> (busy && !done) || early_pulse) else $error("start");
   a_clear_idle: assert property (clear_pulse && !start_pulse
      |=> (!busy && !done) || early_pulse) else $error("clear");
   a_mask_load: assert property (mask_out_pulse && !io_bus_reset
      |=> int_disable == $past(data_in[MASK_BIT])) else $error("mask");
   a_int_follow: assert property (1'b1 |=>
      int_req == $past(done && !int_disable)) else $error("int_req");
endmodule

// [test/io_host.sv]
`timescale 1ns/1ps
// host model: one strobe at a time, optionally a second right behind it
module io_host (
   input  wire logic        core_clk,
   output logic      [10:0] stb,
   output logic      [15:0] d
);
   initial begin
      stb = 11'h000;
      d = 16'h0000;
   end
   // data held while strobing, then the bus shows junk, not the old word
   task pulse(input int i, input int j, input logic [15:0] v);
      @(posedge core_clk);
      stb[i] <= 1'b1;
      d <= v;
      @(posedge core_clk);
      stb[i] <= 1'b0;
      if (j != i) begin
         stb[j] <= 1'b1;
         @(posedge core_clk);
         stb[j] <= 1'b0;
      end
      d <= ~v;
   endtask
   // periodic set-up keeps the read level clear while loads are enabled
   task periodic(input logic [15:0] t);
      pulse(2, 2, 16'h0000 - t);
      pulse(0, 0, 16'h0006);
      pulse(1, 1, 16'h000E);
   endtask
endmodule

// [test/interval_timer_tb_top.sv]
`timescale 1ns/1ps
module interval_timer_tb_top;
   logic        core_clk;
   logic        resetn;
   logic [10:0] stb;
   logic [15:0] d, data_out, count_value;
   logic        data_oe, busy, done, int_disable, int_req, early_pulse;
   int          err_count, n_compared, n;

   io_host h (.core_clk(core_clk), .stb(stb), .d(d));
   // short tick divider keeps overflow runs brief
   interval_timer #(.TICK_CYC(2)) uut (.core_clk(core_clk),
      .resetn(resetn), .write_control_transfer(stb[0]),
      .write_control_with_pulse(stb[1]), .write_preset_transfer(stb[2]),
      .read_control_transfer(stb[3]), .read_count_transfer(stb[4]),
      .start_pulse(stb[5]), .clear_pulse(stb[6]), .io_bus_reset(stb[7]),
      .mask_out_pulse(stb[8]), .data_in(d), .data_out(data_out),
      .data_oe(data_oe), .busy(busy), .done(done),
      .int_disable(int_disable), .int_req(int_req),
      .interrog_pulse(stb[9]), .allcall_reset_pulse(stb[10]),
      .early_pulse(early_pulse), .count_value(count_value));

   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;

   task complete_run;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // transfer, then look once the taking edge has landed
   task op(input int i, input int j, input logic [15:0] v);
      h.pulse(i, j, v);
      #1;
   endtask
   task wait_early;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (early_pulse !== 1'b1 && n < 300);
      if (early_pulse !== 1'b1) begin
         err_count++;
         $display("ERROR %0t: no early pulse", $time);
      end
   endtask

   task t_regs;
      op(0, 0, 16'h0015);
      op(3, 3, 16'h0000);
      chk({data_oe, data_out[14:0]}, 16'h8015);
      op(4, 4, 16'h0000);
      chk({data_oe, data_out[14:0]}, 16'h0000);
      op(7, 7, 16'h0000);
      op(3, 3, 16'h0000);
      chk({data_oe, data_out[14:0]}, 16'h8000);
   endtask
   task t_load;
      op(2, 2, 16'h1234);
      op(1, 1, 16'h0008);
      chk(count_value, 16'h1234);
      op(1, 4, 16'h0040);
      chk(data_out, 16'h1234);
      op(1, 1, 16'h0020);
      chk(count_value, 16'h0000);
   endtask
   task t_freeze;
      op(5, 5, 16'h0000);
      chk({14'h0000, busy, done}, 16'h0002);
      op(2, 2, 16'hFFFD);
      op(1, 1, 16'h000B);
      wait_early;
      chk({14'h0000, busy, done}, 16'h0001);
      repeat (6) @(posedge core_clk);
      #1;
      chk(count_value, 16'hFFFF);
      chk({15'h0000, int_req}, 16'h0001);
      op(3, 3, 16'h0000);
      chk({data_oe, data_out[14:0]}, 16'h800A);
   endtask
   task t_periodic;
      h.periodic(16'h0004);
      wait_early;
      wait_early;
      chk(n[15:0], 16'h0008);
      op(1, 1, 16'h000A);
      wait_early;
      chk(count_value, 16'h0000);
      op(0, 0, 16'h0000);
   endtask
   task t_recv;
      op(2, 2, 16'h0ABC);
      op(1, 1, 16'h0020);
      op(9, 9, 16'h0000);
      chk(count_value, 16'h0000);
      op(0, 0, 16'h0010);
      op(9, 9, 16'h0000);
      chk(count_value, 16'h0ABC);
      op(0, 0, 16'h0030);
      chk(count_value, 16'h0ABC);
      op(10, 10, 16'h0000);
      chk(count_value, 16'h0000);
      op(8, 8, 16'h0001);
      op(6, 6, 16'h0000);
      chk({13'h0000, int_disable, int_req, done}, 16'h0004);
      op(7, 7, 16'h0000);
      chk({15'h0000, int_disable}, 16'h0000);
   endtask

   // watchdog well past the hundred or so cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      complete_run;
   end
   initial begin
      err_count = 0;
      n_compared = 0;
      resetn = 1'b0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs;
      t_load;
      t_freeze;
      t_periodic;
      t_recv;
      complete_run;
   end
endmodule

bind interval_timer interval_timer_sva #(.MASK_BIT(MASK_BIT)) chk_i (
   .core_clk(core_clk), .resetn(resetn),
   .write_control_with_pulse(write_control_with_pulse),
   .read_control_transfer(read_control_transfer),
   .read_count_transfer(read_count_transfer), .start_pulse(start_pulse),
   .clear_pulse(clear_pulse), .io_bus_reset(io_bus_reset),
   .mask_out_pulse(mask_out_pulse), .interrog_pulse(interrog_pulse),
   .allcall_reset_pulse(allcall_reset_pulse), .data_in(data_in),
   .data_out(data_out), .data_oe(data_oe), .busy(busy), .done(done),
   .int_disable(int_disable), .int_req(int_req),
   .early_pulse(early_pulse), .count_value(count_value));
